// ==== common/arith_pkg.sv ====
// Shared constants and types for the multiply/divide/shift accelerator
package arith_pkg;

  // ----------------------------------------------------------------
  // Register selects on the core access port
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_OPND0 = 3'h0;
  localparam logic [2:0] SEL_OPND1 = 3'h1;
  localparam logic [2:0] SEL_OPND2 = 3'h2;
  localparam logic [2:0] SEL_OPND3 = 3'h3;
  localparam logic [2:0] SEL_OPND4 = 3'h4;
  localparam logic [2:0] SEL_OPND5 = 3'h5;
  localparam logic [2:0] SEL_CTRL  = 3'h6;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPND_RST     = 8'h00;
  localparam logic [4:0]  SC_RST       = 5'h00;
  localparam logic [4:0]  SC_NORM      = 5'h00;
  localparam logic [7:0]  RDATA_RST    = 8'h00;
  localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
  localparam int unsigned DIV_STEPS    = 32;
  localparam int unsigned DIV_CNT_W    = 6;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } sfr_req_s;

  // Control and status byte, bit 7 down to bit 0
  typedef struct packed {
    logic       seq_error;
    logic       overflow;
    logic       shift_direction;
    logic [4:0] shift_count;
  } ctrl_s;

  typedef enum logic [4:0] {
    OP_DIV32 = 5'b00001,
    OP_DIV16 = 5'b00010,
    OP_MUL   = 5'b00100,
    OP_NORM  = 5'b01000,
    OP_SHIFT = 5'b10000
  } op_e;

endpackage : arith_pkg

// ==== logic/arith_divider.sv ====
// Iterative restoring divider, 32-bit dividend by 16-bit divisor
`timescale 1ns/1ps
module arith_divider #(
  parameter int unsigned STEPS = arith_pkg::DIV_STEPS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // Result
  output logic             done,
  output logic [31:0]      quot,
  output logic [15:0]      rem
);
  import arith_pkg::*;

  logic [31:0]          quo_r,  quo_nxt;
  logic [15:0]          rem_r,  rem_nxt;
  logic [15:0]          dvs_r,  dvs_nxt;
  logic [31:0]          dvd_r,  dvd_nxt;
  logic [DIV_CNT_W-1:0] cnt_r,  cnt_nxt;
  logic                 done_r, done_nxt;
  logic [17:0]          trial;

  // ----------------------------------------------------------------
  // One quotient bit per cycle
  // ----------------------------------------------------------------
  // 18 bits: the shifted partial remainder can reach 17 bits
  assign trial = {1'b0, rem_r, quo_r[31]} - {2'b00, dvs_r};

  always_comb begin
    quo_nxt  = quo_r;
    rem_nxt  = rem_r;
    dvs_nxt  = dvs_r;
    dvd_nxt  = dvd_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (start) begin
      quo_nxt = dividend;
      rem_nxt = 16'h0000;
      dvs_nxt = divisor;
      dvd_nxt = dividend;
      cnt_nxt = DIV_CNT_W'(STEPS);
    end else if (cnt_r != '0) begin
      if (!trial[17]) begin
        rem_nxt = trial[15:0];
        quo_nxt = {quo_r[30:0], 1'b1};
      end else begin
        rem_nxt = {rem_r[14:0], quo_r[31]};
        quo_nxt = {quo_r[30:0], 1'b0};
      end
      cnt_nxt  = cnt_r - DIV_CNT_W'(1);
      done_nxt = (cnt_r == DIV_CNT_W'(1));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quo_r  <= 32'h0000_0000;
      rem_r  <= 16'h0000;
      dvs_r  <= 16'h0000;
      dvd_r  <= 32'h0000_0000;
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      quo_r  <= quo_nxt;
      rem_r  <= rem_nxt;
      dvs_r  <= dvs_nxt;
      dvd_r  <= dvd_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign quot = quo_r;
  assign rem  = rem_r;

  a_div_identity : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    done_r && dvs_r != 16'h0000 |->
      ({16'h0000, quo_r} * {32'h0000_0000, dvs_r} + {32'h0000_0000, rem_r}
       == {16'h0000, dvd_r}) && rem_r < dvs_r)
    else $error("divider result does not match dividend");

endmodule : arith_divider

// ==== logic/arith_shifter.sv ====
// Registered 32-bit normalizer and barrel shifter
`timescale 1ns/1ps
module arith_shifter (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic        norm,
  input  wire logic        dir,
  input  wire logic [4:0]  count,
  input  wire logic [31:0] value,
  // Result
  output logic             done,
  output logic [31:0]      result,
  output logic [4:0]       lead
);
  import arith_pkg::*;

  logic        done_r, done_nxt;
  logic [31:0] res_r,  res_nxt;
  logic [4:0]  lz_r,   lz_nxt;
  logic [4:0]  lz_now;

  // Zero input counts 32 steps and wraps to 0, leaving the value 0
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       seen;
    n    = 5'h00;
    seen = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!seen && !v[i]) begin
        n = n + 5'h01;
      end else begin
        seen = 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

  // ----------------------------------------------------------------
  // Single-cycle operation, result registered
  // ----------------------------------------------------------------
  assign lz_now = lead_zeros(value);

  always_comb begin
    done_nxt = start;
    res_nxt  = res_r;
    lz_nxt   = lz_r;
    if (start && norm) begin
      res_nxt = value << lz_now;
      lz_nxt  = lz_now;
    end else if (start) begin
      res_nxt = dir ? (value >> count) : (value << count);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      res_r  <= 32'h0000_0000;
      lz_r   <= SC_RST;
    end else begin
      done_r <= done_nxt;
      res_r  <= res_nxt;
      lz_r   <= lz_nxt;
    end
  end

  assign done   = done_r;
  assign result = res_r;
  assign lead   = lz_r;

  a_norm_result : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    start && norm && value != 32'h0000_0000 |=>
      done_r && res_r[31] && (res_r == ($past(value) << lz_r)))
    else $error("normalization left leading zero or wrong count");

  a_shift_dir : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    start && !norm |=> done_r && res_r == ($past(dir) ? ($past(value) >> $past(count))
                                                     : ($past(value) << $past(count))))
    else $error("shift result or direction wrong");

endmodule : arith_shifter

// ==== logic/arith_accelerator.sv ====
// Multiply/divide/normalize/shift accelerator with access-order tracking
// Behaviour
// - Division writes dividend bytes, then divisor bytes
// - Opening byte 0 write restarts operation tracking
// - Last prescribed write launches the computation
// - Division returns quotient then remainder bytes
// - Last prescribed result read ends the operation
// - Multiply writes bytes 0, 4, 1, 5
// - Product appears in bytes 0 to 3
// - Zero count normalizes, removing leading zeroes
// - Normalization leaves leading zero count in shift_count
// - Nonzero count shifts value by that count
// - Direction one shifts right, zero left
// - Write interrupting operation sets sequence error
// - Clean completed operation clears sequence error
// - Reading control register clears sequence error
// - Overflow on zero divisor, product, normalized input
// - Operand registers read/write, reset to zero
`timescale 1ns/1ps
module arith_accelerator (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Register access from the core
  input  wire arith_pkg::sfr_req_s sfr_req,
  // Read data, valid the cycle after a read
  output logic [7:0]               rd_data,
  // Status
  output logic                     busy,
  output logic                     sequence_error_flag,
  output logic                     overflow_flag
);
  import arith_pkg::*;

  typedef enum logic [10:0] {
    ST_IDLE   = 11'b000_0000_0001,
    ST_W0     = 11'b000_0000_0010,
    ST_W01    = 11'b000_0000_0100,
    ST_W012   = 11'b000_0000_1000,
    ST_W0123  = 11'b000_0001_0000,
    ST_W01234 = 11'b000_0010_0000,
    ST_W04    = 11'b000_0100_0000,
    ST_W041   = 11'b000_1000_0000,
    ST_W014   = 11'b001_0000_0000,
    ST_CALC   = 11'b010_0000_0000,
    ST_READ   = 11'b100_0000_0000
  } state_e;

  state_e          state_r, state_nxt, tgt;
  op_e             op_r, op_nxt;
  logic [2:0]      rd_idx_r, rd_idx_nxt;
  logic            start_r, start_nxt;
  logic [5:0][7:0] opnd_r, opnd_nxt;
  logic [4:0]      sc_r, sc_nxt;
  logic            dir_r, dir_nxt;
  logic            err_r, err_nxt;
  logic            ovf_r, ovf_nxt;
  logic [7:0]      rdata_r, rdata_nxt;
  logic            busy_r, busy_nxt;
  logic            viol, done_ok, calc_done, ovf_set;
  logic            wr, rd;
  logic [2:0]      sel;
  ctrl_s           ctrl_wr, ctrl_rd;
  logic [31:0]     product;
  logic [31:0]     dividend;
  logic            div_start, div_done, shf_start, shf_done;
  logic [31:0]     div_quot, shf_result;
  logic [15:0]     div_rem;
  logic [4:0]      shf_lead;

  // ----------------------------------------------------------------
  // Result read order per operation
  // ----------------------------------------------------------------
  function automatic logic [2:0] read_len(input op_e op);
    return (op == OP_DIV32) ? 3'h6 : 3'h4;
  endfunction : read_len

  // 16-bit division skips quotient bytes 2 and 3
  function automatic logic [2:0] read_sel(input op_e op, input logic [2:0] idx);
    return (op == OP_DIV16 && idx >= 3'h2) ? idx + 3'h2 : idx;
  endfunction : read_sel

  assign wr      = sfr_req.wr;
  assign rd      = sfr_req.rd;
  assign sel     = sfr_req.sel;
  assign ctrl_wr = ctrl_s'(sfr_req.wdata);
  assign ctrl_rd = '{seq_error: err_r, overflow: ovf_r,
                     shift_direction: dir_r, shift_count: sc_r};

  // ----------------------------------------------------------------
  // Arithmetic units
  // ----------------------------------------------------------------
  assign product   = {16'h0000, opnd_r[1], opnd_r[0]} * {16'h0000, opnd_r[5], opnd_r[4]};
  assign dividend  = (op_r == OP_DIV16) ? {16'h0000, opnd_r[1], opnd_r[0]} : opnd_r[3:0];
  assign div_start = start_r && (op_r == OP_DIV32 || op_r == OP_DIV16);
  assign shf_start = start_r && (op_r == OP_NORM || op_r == OP_SHIFT);

  arith_divider #(
    .STEPS    (DIV_STEPS)
  ) u_divider (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (div_start),
    .dividend (dividend),
    .divisor  ({opnd_r[5], opnd_r[4]}),
    .done     (div_done),
    .quot     (div_quot),
    .rem      (div_rem)
  );

  arith_shifter u_shifter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (shf_start),
    .norm     (op_r == OP_NORM),
    .dir      (dir_r),
    .count    (sc_r),
    .value    (opnd_r[3:0]),
    .done     (shf_done),
    .result   (shf_result),
    .lead     (shf_lead)
  );

  always_comb begin
    calc_done = 1'b0;
    unique case (op_r)
      OP_DIV32, OP_DIV16: calc_done = div_done;
      OP_MUL:             calc_done = start_r;
      OP_NORM, OP_SHIFT:  calc_done = shf_done;
    endcase
  end

  // ----------------------------------------------------------------
  // Access-order tracking
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    rd_idx_nxt = rd_idx_r;
    start_nxt  = 1'b0;
    viol       = 1'b0;
    done_ok    = 1'b0;
    tgt        = ST_IDLE;
    if (wr && sel == SEL_OPND0) begin
      viol      = (state_r != ST_IDLE);
      state_nxt = ST_W0;
    end else if (wr && sel <= SEL_CTRL) begin
      unique case (state_r)
        ST_IDLE:   tgt = ST_IDLE;
        ST_W0:     tgt = (sel == SEL_OPND1) ? ST_W01 : (sel == SEL_OPND4) ? ST_W04 : ST_IDLE;
        ST_W01:    tgt = (sel == SEL_OPND2) ? ST_W012 : (sel == SEL_OPND4) ? ST_W014 : ST_IDLE;
        ST_W012:   tgt = (sel == SEL_OPND3) ? ST_W0123 : ST_IDLE;
        ST_W0123: begin
          if (sel == SEL_OPND4) begin
            tgt = ST_W01234;
          end else if (sel == SEL_CTRL) begin
            tgt    = ST_CALC;
            op_nxt = (ctrl_wr.shift_count == SC_NORM) ? OP_NORM : OP_SHIFT;
          end
        end
        ST_W01234: begin
          if (sel == SEL_OPND5) begin
            tgt    = ST_CALC;
            op_nxt = OP_DIV32;
          end
        end
        ST_W04:    tgt = (sel == SEL_OPND1) ? ST_W041 : ST_IDLE;
        ST_W041: begin
          if (sel == SEL_OPND5) begin
            tgt    = ST_CALC;
            op_nxt = OP_MUL;
          end
        end
        ST_W014: begin
          if (sel == SEL_OPND5) begin
            tgt    = ST_CALC;
            op_nxt = OP_DIV16;
          end
        end
        ST_CALC:   tgt = ST_IDLE;
        ST_READ:   tgt = ST_IDLE;
      endcase
      // Out-of-order write aborts the operation
      viol      = (state_r != ST_IDLE) && (tgt == ST_IDLE);
      start_nxt = (tgt == ST_CALC);
      state_nxt = tgt;
    end else if (state_r == ST_CALC && calc_done) begin
      state_nxt  = ST_READ;
      rd_idx_nxt = 3'h0;
    end else if (state_r == ST_READ && rd && sel == read_sel(op_r, rd_idx_r)) begin
      if (rd_idx_r == read_len(op_r) - 3'h1) begin
        state_nxt = ST_IDLE;
        done_ok   = 1'b1;
      end else begin
        rd_idx_nxt = rd_idx_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operand, control and status registers
  // ----------------------------------------------------------------
  always_comb begin
    opnd_nxt = opnd_r;
    sc_nxt   = sc_r;
    dir_nxt  = dir_r;
    ovf_set  = 1'b0;
    if (wr && sel < SEL_CTRL) begin
      opnd_nxt[sel] = sfr_req.wdata;
    end else if (wr && sel == SEL_CTRL) begin
      sc_nxt  = ctrl_wr.shift_count;
      dir_nxt = ctrl_wr.shift_direction;
    end else if (state_r == ST_CALC && calc_done) begin
      unique case (op_r)
        OP_DIV32, OP_DIV16: begin
          opnd_nxt[3:0] = div_quot;
          opnd_nxt[5:4] = div_rem;
          ovf_set       = ({opnd_r[5], opnd_r[4]} == 16'h0000);
        end
        OP_MUL: begin
          opnd_nxt[3:0] = product;
          ovf_set       = (product[31:16] != 16'h0000);
        end
        OP_NORM: begin
          opnd_nxt[3:0] = shf_result;
          sc_nxt        = shf_lead;
          ovf_set       = opnd_r[3][7];
        end
        OP_SHIFT: begin
          opnd_nxt[3:0] = shf_result;
        end
      endcase
    end
    // Hardware set wins over the clearing access in the same cycle
    err_nxt   = viol | (err_r & ~(done_ok | (rd && sel == SEL_CTRL)));
    ovf_nxt   = ovf_set | (ovf_r & ~(wr && sel == SEL_OPND0));
    busy_nxt  = (state_nxt == ST_CALC);
    rdata_nxt = rdata_r;
    if (rd) begin
      rdata_nxt = (sel < SEL_CTRL) ? opnd_r[sel] :
                  (sel == SEL_CTRL) ? 8'(ctrl_rd) : UNMAPPED_VAL;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      op_r     <= OP_DIV32;
      rd_idx_r <= 3'h0;
      start_r  <= 1'b0;
      opnd_r   <= {6{OPND_RST}};
      sc_r     <= SC_RST;
      dir_r    <= 1'b0;
      err_r    <= 1'b0;
      ovf_r    <= 1'b0;
      rdata_r  <= RDATA_RST;
      busy_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      rd_idx_r <= rd_idx_nxt;
      start_r  <= start_nxt;
      opnd_r   <= opnd_nxt;
      sc_r     <= sc_nxt;
      dir_r    <= dir_nxt;
      err_r    <= err_nxt;
      ovf_r    <= ovf_nxt;
      rdata_r  <= rdata_nxt;
      busy_r   <= busy_nxt;
    end
  end

  assign rd_data             = rdata_r;
  assign busy                = busy_r;
  assign sequence_error_flag = err_r;
  assign overflow_flag       = ovf_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_div_last_write;
    state_r == ST_W01234 && wr && sel == SEL_OPND5;
  endsequence

  sequence s_calc_launched;
    state_r == ST_CALC && start_r;
  endsequence

  a_open_restart : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr && sel == SEL_OPND0 |=> state_r == ST_W0 && !ovf_r)
    else $error("opening write did not restart tracking");

  a_div_launch : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_div_last_write |=> s_calc_launched ##0 op_r == OP_DIV32)
    else $error("last divisor write did not launch division");

  a_mul_launch : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_r == ST_W041 && wr && sel == SEL_OPND5 |=> s_calc_launched ##0 op_r == OP_MUL)
    else $error("multiply write order did not launch");

  a_calc_bounded : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_calc_launched |-> ##[1:34] state_r != ST_CALC)
    else $error("operation exceeded its cycle budget");

  a_mul_product : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_r == ST_CALC && op_r == OP_MUL && start_r && !wr |=>
      opnd_r[3:0] == $past(product) && state_r == ST_READ)
    else $error("product not stored in operand bytes");

  a_last_read : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_r == ST_READ && rd && !wr && sel == read_sel(op_r, rd_idx_r)
      && rd_idx_r == read_len(op_r) - 3'h1 |=> state_r == ST_IDLE && !err_r)
    else $error("final result read did not end operation");

  a_restart_err : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr && sel == SEL_OPND0 && state_r != ST_IDLE |=> err_r ##1 (err_r || rd || done_ok))
    else $error("restart did not set sequence error");

  a_ctrl_clear : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd && sel == SEL_CTRL && !viol |=> !err_r && rdata_r[7] == $past(err_r))
    else $error("control read did not clear sequence error");

  a_div_zero : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_r == ST_CALC && div_done && !wr && {opnd_r[5], opnd_r[4]} == 16'h0000
      && (op_r == OP_DIV32 || op_r == OP_DIV16) |=> ovf_r)
    else $error("zero divisor did not flag overflow");

endmodule : arith_accelerator

// ==== tb/cpu_model.sv ====
// Core-side register access model for the accelerator
`timescale 1ns/1ps
module cpu_model (
  // Clock
  input  wire logic           core_clk,
  // Register access port
  output arith_pkg::sfr_req_s sfr_req,
  input  wire logic [7:0]     rd_data
);
  import arith_pkg::*;

  initial sfr_req = '{1'b0, 1'b0, SEL_CTRL, 8'h00};

  // Lines scrambled on release so stale values never look valid
  task automatic wr(input logic [2:0] sel, input logic [7:0] data);
    @(negedge core_clk);
    sfr_req = '{1'b1, 1'b0, sel, data};
    @(negedge core_clk);
    sfr_req = '{1'b0, 1'b0, ~sel, ~data};
  endtask : wr

  // Read data taken one cycle after the strobe
  task automatic rd(input logic [2:0] sel, output logic [7:0] data);
    @(negedge core_clk);
    sfr_req = '{1'b0, 1'b1, sel, ~sfr_req.wdata};
    @(negedge core_clk);
    data = rd_data;
    sfr_req = '{1'b0, 1'b0, ~sel, sfr_req.wdata};
  endtask : rd
endmodule : cpu_model

// ==== tb/test_arith_accelerator.sv ====
// Self-checking bench for the arithmetic accelerator
`timescale 1ns/1ps
module test_arith_accelerator;
  import arith_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  sfr_req_s   sfr_req;
  logic [7:0] rd_data;
  logic       busy;
  logic       sequence_error_flag;
  logic       overflow_flag;
  int         n_errors = 0;
  int         checks   = 0;

  always #2.5 core_clk = ~core_clk;

  arith_accelerator DUT (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(sfr_req),
    .rd_data(rd_data), .busy(busy), .sequence_error_flag(sequence_error_flag),
    .overflow_flag(overflow_flag));
  cpu_model u_cpu (.core_clk(core_clk), .sfr_req(sfr_req), .rd_data(rd_data));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d, n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Bounded so a stuck busy shows as a wrong count
  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_idle

  // --------------------------------------------------------------
  // One operation: ordered writes, timed calculation, ordered reads
  // --------------------------------------------------------------
  task automatic op(input logic [23:0] wo, input int nw, input logic [55:0] img,
                    input int cyc, input logic [23:0] ro, input int nr,
                    input logic [47:0] res, input logic [1:0] flg, output logic [7:0] ctl);
    logic [7:0] d;
    int         n;
    for (int i = 0; i < nw; i++) u_cpu.wr(wo[4*i+:3], img[8*wo[4*i+:3]+:8]);
    wait_idle(n);
    chk(n, cyc);
    for (int i = 0; i < nr; i++) begin
      u_cpu.rd(ro[4*i+:3], d);
      chk(d, res[8*ro[4*i+:3]+:8]);
    end
    chk({sequence_error_flag, overflow_flag}, flg);
    u_cpu.rd(SEL_CTRL, ctl);
    chk(ctl[7:6], flg);
  endtask : op

  task automatic t_reset;
    logic [7:0] d;
    u_cpu.wr(3'h7, 8'hFF);
    for (int s = 0; s < 8; s++) begin
      u_cpu.rd(s[2:0], d);
      chk(d, 8'h00);
    end
    u_cpu.wr(SEL_OPND3, 8'hA5);
    u_cpu.rd(SEL_OPND3, d);
    chk(d, 8'hA5);
  endtask : t_reset

  task automatic t_div;
    logic [31:0] a = 32'h1234_5678;
    logic [15:0] b = 16'h00AB;
    logic [15:0] c = 16'hBEEF;
    logic [7:0]  x;
    op(24'h543210, 6, {8'h00, b, a}, 34, 24'h543210, 6,
       {16'(a % b), a / b}, 2'b00, x);
    op(24'h5410, 4, {8'h00, b, 16'h0000, c}, 34, 24'h5410, 4,
       {16'(c % b), 16'h0000, c / b}, 2'b00, x);
  endtask : t_div

  task automatic t_mul;
    logic [15:0] m = 16'h1234;
    logic [15:0] k;
    logic [7:0]  x;
    for (int i = 0; i < 2; i++) begin
      k = i ? 16'h1000 : 16'h0005;
      op(24'h5140, 4, {8'h00, k, 16'h0000, m}, 1, 24'h3210, 4,
         {16'h0000, 32'(m) * 32'(k)}, {1'b0, i == 1}, x);
    end
  endtask : t_mul

  task automatic t_shift;
    logic [31:0] v = 32'h9234_5678;
    logic [31:0] tbl = 32'h1F3F_2404;
    logic [7:0]  c;
    logic [7:0]  x;
    op(24'h63210, 5, {8'h00, 16'h0000, 32'h0001_2345}, 2, 24'h3210, 4,
       {16'h0000, 32'h91A2_8000}, 2'b00, x);
    chk(x[4:0], 5'h0F);
    op(24'h63210, 5, {8'h00, 16'h0000, 32'h8000_0001}, 2, 24'h3210, 4,
       {16'h0000, 32'h8000_0001}, 2'b01, x);
    for (int i = 0; i < 4; i++) begin
      c = tbl[8*i+:8];
      op(24'h63210, 5, {c, 16'h0000, v}, 2, 24'h3210, 4,
         {16'h0000, c[5] ? v >> c[4:0] : v << c[4:0]}, 2'b00, x);
    end
  endtask : t_shift

  task automatic t_seq;
    logic [7:0] d;
    int         n;
    for (int i = 0; i < 6; i++) u_cpu.wr(i[2:0], (i < 4) ? 8'h11 : 8'h00);
    wait_idle(n);
    chk(overflow_flag, 1'b1);
    u_cpu.wr(SEL_OPND0, 8'h01);
    chk({sequence_error_flag, overflow_flag}, 2'b10);
    u_cpu.rd(SEL_CTRL, d);
    chk(d[7:6], 2'b10);
    chk(sequence_error_flag, 1'b0);
    u_cpu.wr(SEL_OPND4, 8'h02);
    u_cpu.wr(SEL_OPND2, 8'h03);
    chk(sequence_error_flag, 1'b1);
    for (int i = 0; i < 6; i++) u_cpu.wr(i[2:0], 8'h22);
    chk(busy, 1'b1);
    u_cpu.wr(SEL_OPND1, 8'h00);
    chk({busy, sequence_error_flag}, 2'b01);
    op(24'h5140, 4, {8'h00, 16'h0003, 16'h0000, 16'h0007}, 1, 24'h3210, 4,
       {16'h0000, 32'h0000_0015}, 2'b00, d);
  endtask : t_seq

  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_div();
    t_mul();
    t_shift();
    t_seq();
    end_sim();
  end

  // About twenty-five times the expected run
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
endmodule : test_arith_accelerator
